// File: hdl/scbu_serial_cfg.sv
`timescale 1ns/1ps
`default_nettype none
`include "scbu_consts.svh"
module scbu_serial_cfg
    import scbu_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // serial control port pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdio,
    output logic o_sdio,
    output logic o_sdio_oe,
    output logic o_sdo,
    output logic o_sdo_oe,
    // download straps (pins)
    input wire logic i_nvm_load_en,
    input wire logic i_pin_prog_en,
    // load sequence memory, one cycle read latency
    output logic [`SCBU_NVM_AW-1:0] o_nvm_addr,
    input wire logic [7:0] i_nvm_data,
    // save image read port
    input wire logic [`SCBU_AW-1:0] i_save_addr,
    output logic [7:0] o_save_data,
    // device side
    input wire logic [7:0] i_status,
    output logic [`SCBU_BANK_N-1:0][7:0] o_active_regs,
    output logic o_four_wire,
    output logic o_commit,
    output logic o_soft_reset,
    output logic o_pll_cal_start,
    output logic o_loading
);
    // pin synchronisers: sclk, cs_n, sdio, nvm strap, pin strap
    logic [4:0] s1_q, s2_q;
    logic sclk_prev_q;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= 5'h02;
            s2_q <= 5'h02;
            sclk_prev_q <= 1'b0;
        end else begin
            s1_q <= {i_pin_prog_en, i_nvm_load_en, i_sdio, i_cs_n, i_sclk};
            s2_q <= s1_q;
            sclk_prev_q <= s2_q[0];
        end
    end
    logic sclk_rise, sclk_fall, cs_n_s, sdi_s, nvm_s, pin_s;
    assign sclk_rise = s2_q[0] & ~sclk_prev_q;
    assign sclk_fall = ~s2_q[0] & sclk_prev_q;
    assign cs_n_s = s2_q[1];
    assign sdi_s = s2_q[2];
    assign nvm_s = s2_q[3];
    assign pin_s = s2_q[4];
    // register state
    logic [1:0] cfg_q, cfg_d; // {four-wire, lsb-first}
    logic rbk_q, rbk_d; // read pending buffer
    logic [`SCBU_BANK_N-1:0][7:0] pend_q, pend_d; // host-visible buffer
    logic [`SCBU_BANK_N-1:0][7:0] act_q, act_d; // applied values
    logic [7:0] stat_q, stat_d; // status snapshot
    logic commit_q, commit_d, srst_q, srst_d; // one-cycle pulses
    logic [7:0] save_q, save_d;
    logic lsb;
    assign lsb = cfg_q[0];
    // register read mux, sel picks the pending side of the bank
    function automatic logic [7:0] reg_read(
        input logic [`SCBU_AW-1:0] a,
        input logic sel
    );
        logic [7:0] r;
        r = 8'h00; // unmapped reads as zero
        case (a)
            `SCBU_OFS_CFG: r = {cfg_q, 6'h00}; // soft reset bit reads clear
            `SCBU_OFS_RBK: r = {7'h00, rbk_q};
            `SCBU_OFS_UPD: r = 8'h00; // [R08]
            `SCBU_OFS_STAT: r = stat_q;
            default: begin
                if (a[`SCBU_AW-1:3] == `SCBU_BANK_TAG) begin
                    r = sel ? pend_q[a[2:0]] : act_q[a[2:0]]; // [R06]
                end
            end
        endcase
        return r;
    endfunction
    // next address of a multibyte transfer
    function automatic logic [`SCBU_AW-1:0] step(
        input logic [`SCBU_AW-1:0] a, input logic up);
        return up ? `SCBU_AW'(a + 1'b1) : `SCBU_AW'(a - 1'b1);
    endfunction
    // serial engine state
    scbu_phase_t ph_q, ph_d;
    logic [15:0] sh_q, sh_d;
    logic [4:0] cnt_q, cnt_d;
    logic rd_q, rd_d;
    logic [`SCBU_AW-1:0] addr_q, addr_d;
    logic [7:0] tx_q, tx_d;
    logic fresh_q, fresh_d;
    logic spi_wr;
    logic [7:0] spi_wdata;
    logic [15:0] nxt_sh;
    // serial engine: sample on sclk rise, shift out on sclk fall
    always_comb begin
        ph_d = ph_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        addr_d = addr_q;
        tx_d = tx_q;
        fresh_d = fresh_q;
        spi_wr = 1'b0;
        spi_wdata = 8'h00;
        nxt_sh = lsb ? {sdi_s, sh_q[15:1]} : {sh_q[14:0], sdi_s}; // [R02] [R03]
        if (cs_n_s) begin // deselect always restarts framing
            ph_d = P_INSTR;
            cnt_d = 5'd0;
            rd_d = 1'b0;
            fresh_d = 1'b0;
        end else if (sclk_rise) begin
            sh_d = nxt_sh;
            cnt_d = 5'(cnt_q + 1'b1);
            if (ph_q == P_INSTR && cnt_q == `SCBU_INSTR_LAST) begin
                // instruction done: latch address, preload read byte
                ph_d = P_DATA;
                cnt_d = 5'd0;
                rd_d = nxt_sh[`SCBU_RD_BIT];
                addr_d = nxt_sh[`SCBU_AW-1:0];
                tx_d = reg_read(nxt_sh[`SCBU_AW-1:0], rbk_q);
                fresh_d = 1'b1;
            end else if (ph_q == P_DATA && cnt_q == `SCBU_BYTE_LAST) begin
                cnt_d = 5'd0;
                addr_d = step(addr_q, lsb); // [R02] [R03]
                if (rd_q) begin
                    tx_d = reg_read(step(addr_q, lsb), rbk_q);
                    fresh_d = 1'b1;
                end else begin
                    spi_wr = 1'b1;
                    spi_wdata = lsb ? nxt_sh[15:8] : nxt_sh[7:0];
                end
            end
        end else if (sclk_fall && ph_q == P_DATA && rd_q) begin
            // first fall after a load only exposes the first bit
            fresh_d = 1'b0;
            if (!fresh_q) begin
                tx_d = lsb ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
            end
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_q <= P_INSTR;
            sh_q <= 16'h0000;
            cnt_q <= 5'd0;
            rd_q <= 1'b0;
            addr_q <= `SCBU_OFS_CFG;
            tx_q <= 8'h00;
            fresh_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            tx_q <= tx_d;
            fresh_q <= fresh_d;
        end
    end
    // pin drive: one bit source, routed by the wire mode
    logic rd_drive;
    assign rd_drive = ~cs_n_s & rd_q & (ph_q == P_DATA);
    assign o_sdio = lsb ? tx_q[0] : tx_q[7];
    assign o_sdo = lsb ? tx_q[0] : tx_q[7];
    assign o_sdio_oe = rd_drive & ~cfg_q[1]; // [R01]
    assign o_sdo_oe = rd_drive & cfg_q[1]; // [R01]
    assign o_four_wire = cfg_q[1];
    // loader state
    scbu_ld_state_t ld_q, ld_d;
    logic [`SCBU_NVM_AW-1:0] ptr_q, ptr_d;
    logic wait_q, wait_d, cal_q, cal_d; // memory wait, calibration pulse
    logic [6:0] lcnt_q, lcnt_d;
    logic [`SCBU_AW-1:0] ladr_q, ladr_d;
    logic ld_wr, ld_commit;
    // sequence interpreter; each byte costs a wait cycle for memory
    always_comb begin
        ld_d = ld_q;
        ptr_d = ptr_q;
        wait_d = wait_q;
        lcnt_d = lcnt_q;
        ladr_d = ladr_q;
        cal_d = 1'b0;
        ld_wr = 1'b0;
        ld_commit = 1'b0;
        if (ld_q != L_IDLE && wait_q) begin
            wait_d = 1'b0; // data for ptr_q valid next cycle
        end else begin
            if (ld_q != L_IDLE) begin
                ptr_d = `SCBU_NVM_AW'(ptr_q + 1'b1);
                wait_d = 1'b1;
            end
            case (ld_q)
                L_IDLE: begin
                    if (srst_q && (nvm_s || pin_s)) begin // [R04]
                        // pin program wins: the pins override memory
                        ld_d = L_CODE;
                        ptr_d = pin_s ? `SCBU_PIN_SEQ_START : `SCBU_SEQ_START;
                        wait_d = 1'b1;
                    end
                end
                L_CODE: begin // other action codes are skipped
                    if (i_nvm_data == `SCBU_CODE_END) begin
                        ld_d = L_IDLE; // [R13]
                        wait_d = 1'b0;
                    end else if (i_nvm_data == `SCBU_CODE_UPDATE) begin
                        ld_commit = 1'b1; // [R13]
                    end else if (i_nvm_data == `SCBU_CODE_CAL) begin
                        cal_d = 1'b1; // [R12]
                    end else if (i_nvm_data < `SCBU_CODE_ACT_MIN) begin
                        lcnt_d = i_nvm_data[6:0]; // [R13]
                        ld_d = L_AHI;
                    end
                end
                L_AHI: begin
                    ladr_d = {i_nvm_data[4:0], ladr_q[7:0]};
                    ld_d = L_ALO;
                end
                L_ALO: begin
                    ladr_d = {ladr_q[`SCBU_AW-1:8], i_nvm_data};
                    ld_d = L_DATA;
                end
                L_DATA: begin
                    // count byte holds length minus one [R11]
                    ld_wr = 1'b1;
                    ladr_d = `SCBU_AW'(ladr_q + 1'b1);
                    if (lcnt_q == 7'd0) begin
                        ld_d = L_CODE;
                    end else begin
                        lcnt_d = 7'(lcnt_q - 1'b1);
                    end
                end
                default: begin
                    ld_d = L_IDLE;
                    wait_d = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ld_q <= L_IDLE;
            ptr_q <= `SCBU_SEQ_START;
            wait_q <= 1'b0;
            lcnt_q <= 7'd0;
            ladr_q <= `SCBU_OFS_CFG;
            cal_q <= 1'b0;
        end else begin
            ld_q <= ld_d;
            ptr_q <= ptr_d;
            wait_q <= wait_d;
            lcnt_q <= lcnt_d;
            ladr_q <= ladr_d;
            cal_q <= cal_d;
        end
    end
    assign o_nvm_addr = ptr_q;
    assign o_loading = (ld_q != L_IDLE);
    assign o_pll_cal_start = cal_q;
    // loader owns the write port; host writes dropped so loads never tear
    logic wr_en, host_wr;
    logic [`SCBU_AW-1:0] wr_addr;
    logic [7:0] wr_data;
    assign host_wr = spi_wr & ~o_loading;
    assign wr_en = o_loading ? ld_wr : spi_wr;
    assign wr_addr = o_loading ? ladr_q : addr_q;
    assign wr_data = o_loading ? i_nvm_data : spi_wdata;
    // register bank next state
    always_comb begin
        cfg_d = cfg_q;
        rbk_d = rbk_q;
        pend_d = pend_q;
        act_d = act_q;
        stat_d = stat_q;
        commit_d = ld_commit;
        srst_d = 1'b0;
        // save image excludes the port configuration
        save_d = (i_save_addr == `SCBU_OFS_CFG) ? 8'h00 :
            reg_read(i_save_addr, 1'b1); // [R05]
        if (srst_q) begin
            // soft reset returns every register to default
            cfg_d = `SCBU_CFG_RST; // [R04]
            rbk_d = `SCBU_RBK_RST;
            pend_d = '0;
            act_d = '0;
            stat_d = `SCBU_STAT_RST;
            commit_d = 1'b0;
        end else begin
            if (host_wr && wr_addr == `SCBU_OFS_CFG) begin
                // live: wire mode and bit order act at once
                cfg_d = {wr_data[`SCBU_CFG_SDO_BIT],
                    wr_data[`SCBU_CFG_LSB_BIT]}; // [R01] [R09]
                srst_d = wr_data[`SCBU_CFG_RST_BIT]; // [R04]
            end
            if (host_wr && wr_addr == `SCBU_OFS_RBK) begin
                rbk_d = wr_data[`SCBU_RBK_SEL_BIT]; // [R09]
            end
            if (host_wr && wr_addr == `SCBU_OFS_UPD &&
                wr_data[`SCBU_UPD_BIT]) begin
                commit_d = 1'b1; // [R07]
            end
            if (wr_en && wr_addr[`SCBU_AW-1:3] == `SCBU_BANK_TAG) begin
                pend_d[wr_addr[2:0]] = wr_data; // [R09] [R11]
            end
            if (commit_q) begin
                // update bit is never stored, so it reads zero [R08]
                act_d = pend_q; // [R07]
                stat_d = i_status; // [R10]
            end
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= `SCBU_CFG_RST;
            rbk_q <= `SCBU_RBK_RST;
            pend_q <= '0;
            act_q <= '0;
            stat_q <= `SCBU_STAT_RST;
            commit_q <= 1'b0;
            srst_q <= 1'b0;
            save_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            rbk_q <= rbk_d;
            pend_q <= pend_d;
            act_q <= act_d;
            stat_q <= stat_d;
            commit_q <= commit_d;
            srst_q <= srst_d;
            save_q <= save_d;
        end
    end
    assign o_active_regs = act_q;
    assign o_commit = commit_q;
    assign o_soft_reset = srst_q;
    assign o_save_data = save_q;
endmodule
`default_nettype wire

// File: include/scbu_consts.svh
`ifndef SCBU_CONSTS_SVH
`define SCBU_CONSTS_SVH
// Functional notes
// [R01] config bit 7 selects four-wire readback output
// [R02] bit 6 set: LSB first, addresses step up
// [R03] bit 6 clear: MSB first, addresses step down
// [R04] soft reset bit resets, may start download
// [R05] config register never enters the save image
// [R06] readback bit picks pending or active values
// [R07] update bit copies pending into active
// [R08] update bit clears itself, reads zero
// [R09] live registers act at once, others on commit
// [R10] status snapshot refreshes only on commit
// [R11] reference entry loads four bytes at 0x0600
// [R12] code A0 starts output_pll calibration
// [R13] sequence: count, address, update, end codes

// register offsets and widths
`define SCBU_AW 13
`define SCBU_OFS_CFG 13'h0000
`define SCBU_OFS_RBK 13'h0004
`define SCBU_OFS_UPD 13'h0005
`define SCBU_OFS_STAT 13'h0d00
// buffered bank: eight bytes from 0x0600, tag is offset >> 3
`define SCBU_BANK_TAG 10'h0c0
`define SCBU_BANK_N 8

// field positions
`define SCBU_CFG_SDO_BIT 7
`define SCBU_CFG_LSB_BIT 6
`define SCBU_CFG_RST_BIT 5
`define SCBU_RBK_SEL_BIT 0
`define SCBU_UPD_BIT 0

// reset values
`define SCBU_CFG_RST 2'h0
`define SCBU_RBK_RST 1'h0
`define SCBU_BANK_RST 8'h00
`define SCBU_STAT_RST 8'h00

// load sequence codes
`define SCBU_CODE_UPDATE 8'h80
`define SCBU_CODE_CAL 8'ha0
`define SCBU_CODE_END 8'hff
`define SCBU_CODE_ACT_MIN 8'h80
`define SCBU_NVM_AW 10
`define SCBU_SEQ_START 10'h000
`define SCBU_PIN_SEQ_START 10'h200

// serial framing counts
`define SCBU_INSTR_LAST 5'd15
`define SCBU_BYTE_LAST 5'd7
`define SCBU_RD_BIT 15
`endif

// File: include/scbu_pkg.sv
package scbu_pkg;
    // load sequence interpreter states
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_CODE = 3'b001,
        L_AHI = 3'b010,
        L_ALO = 3'b011,
        L_DATA = 3'b100
    } scbu_ld_state_t;
    // serial frame phase
    typedef enum logic {
        P_INSTR = 1'b0,
        P_DATA = 1'b1
    } scbu_phase_t;
endpackage

// File: test/scbu_serial_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "scbu_consts.svh"
module scbu_serial_cfg_props (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // download straps
    input wire logic i_nvm_load_en,
    input wire logic i_pin_prog_en,
    // outputs under watch
    input wire logic o_sdio_oe,
    input wire logic o_sdo_oe,
    input wire logic [`SCBU_NVM_AW-1:0] o_nvm_addr,
    input wire logic [`SCBU_BANK_N-1:0][7:0] o_active_regs,
    input wire logic o_four_wire,
    input wire logic o_commit,
    input wire logic o_soft_reset,
    input wire logic o_pll_cal_start,
    input wire logic o_loading
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // soft reset with a strap up, so a download is due
    sequence s_load_due;
        o_soft_reset && (i_nvm_load_en || i_pin_prog_en);
    endsequence
    // loader busy and its fetch address moved; start jump left out
    sequence s_step;
        o_loading && $past(o_loading) && $past(o_nvm_addr) != 10'h000 &&
            o_nvm_addr != $past(o_nvm_addr);
    endsequence
    commit_pulse_a: assert property (o_commit |=> !o_commit)
        else $error("commit pulse too long");
    active_hold_a: assert property ($changed(o_active_regs) |->
        $past(o_commit) || $past(o_soft_reset))
        else $error("active bank moved without commit");
    soft_clear_a: assert property (o_soft_reset |=>
        !o_soft_reset && o_active_regs == '0)
        else $error("soft reset left bank set");
    load_start_a: assert property (s_load_due |-> ##[1:3] o_loading)
        else $error("download did not start");
    cal_in_load_a: assert property (o_pll_cal_start |->
        o_loading ##1 !o_pll_cal_start)
        else $error("calibration pulse outside load");
    sdo_mode_a: assert property (o_sdo_oe |-> o_four_wire)
        else $error("sdo driven in three-wire mode");
    sdio_mode_a: assert property (o_sdio_oe |-> !o_four_wire)
        else $error("sdio driven in four-wire mode");
    nvm_step_a: assert property (s_step |->
        o_nvm_addr == $past(o_nvm_addr) + 10'h001)
        else $error("sequence address skipped");
endmodule
bind scbu_serial_cfg scbu_serial_cfg_props i_props (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_nvm_load_en(i_nvm_load_en), .i_pin_prog_en(i_pin_prog_en),
    .o_sdio_oe(o_sdio_oe), .o_sdo_oe(o_sdo_oe), .o_nvm_addr(o_nvm_addr),
    .o_active_regs(o_active_regs), .o_four_wire(o_four_wire),
    .o_commit(o_commit), .o_soft_reset(o_soft_reset),
    .o_pll_cal_start(o_pll_cal_start), .o_loading(o_loading));
`default_nettype wire

// File: test/scbu_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module scbu_spi_host (
    // system clock paces the bit timing
    input wire logic i_clk,
    // resolved data lines
    input wire logic i_sdio,
    input wire logic i_sdo,
    // host drive toward the port
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_d,
    output logic o_oe
);
    logic lsb; // bit order the host follows
    logic four; // read data taken from the dedicated output
    initial begin
        {lsb, four, o_sclk, o_cs_n, o_d, o_oe} = 6'b000100;
    end
    // six clocks a half bit, above the synchroniser's minimum
    task automatic half();
        repeat (6) @(posedge i_clk);
        #1;
    endtask
    // data set while sclk is low, both sides take it at the rise
    task automatic bit_io(input logic b, input logic drv, output logic r);
        o_d = b;
        o_oe = drv;
        half();
        o_sclk = 1'b1;
        r = four ? i_sdo : i_sdio;
        half();
        o_sclk = 1'b0;
    endtask
    // whole frame; sclk rests low outside it
    task automatic frame(input logic rd, input logic [12:0] a, input int n,
            input logic [7:0] wd[8], output logic [7:0] rv[8]);
        logic [15:0] ins;
        logic r;
        ins = {rd, 2'b00, a};
        o_cs_n = 1'b0;
        half();
        for (int i = 0; i < 16; i++)
            bit_io(ins[lsb ? i : 15 - i], 1'b1, r);
        for (int k = 0; k < n; k++)
            for (int i = 0; i < 8; i++) begin
                bit_io(wd[k][lsb ? i : 7 - i], !rd, r);
                rv[k][lsb ? i : 7 - i] = r;
            end
        o_oe = 1'b0;
        half();
        o_cs_n = 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scbu_consts.svh"
module tb;
    logic clk, rst_n, sclk, cs_n, host_d, host_oe, pat_q, sdio_ln, sdo_ln;
    logic d_sdio, d_sdio_oe, d_sdo, d_sdo_oe, four, commit, srst, cal, loading;
    logic nvm_ld, pin_pg;
    logic [`SCBU_NVM_AW-1:0] nvm_addr;
    logic [`SCBU_AW-1:0] save_addr;
    logic [7:0] nvm_data, save_data, status;
    logic [`SCBU_BANK_N-1:0][7:0] active;
    logic [7:0] nvm [1024]; // load sequence memory
    int fails = 0, samples_checked = 0, n_commit = 0, n_cal = 0, n_srst = 0;
    localparam logic [7:0] seq_nvm [10] = '{8'h03, 8'h06, 8'h00, 8'h11,
        8'h22, 8'h33, 8'h44, 8'ha0, 8'h80, 8'hff};
    localparam logic [7:0] seq_pin [6] = '{8'h00, 8'h06, 8'h07, 8'h55,
        8'h80, 8'hff};
    // released lines toggle, so a stale bit never passes
    assign sdio_ln = d_sdio_oe ? d_sdio : (host_oe ? host_d : pat_q);
    assign sdo_ln = d_sdo_oe ? d_sdo : pat_q;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // memory answers a clock after the address; pulses tallied
    always @(posedge clk) begin
        nvm_data <= #1 nvm[nvm_addr];
        pat_q <= ~pat_q;
        n_commit <= n_commit + (commit === 1'b1 ? 1 : 0);
        n_cal <= n_cal + (cal === 1'b1 ? 1 : 0);
        n_srst <= n_srst + (srst === 1'b1 ? 1 : 0);
    end
    scbu_serial_cfg i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_sdio(sdio_ln), .o_sdio(d_sdio),
        .o_sdio_oe(d_sdio_oe), .o_sdo(d_sdo), .o_sdo_oe(d_sdo_oe),
        .i_nvm_load_en(nvm_ld), .i_pin_prog_en(pin_pg),
        .o_nvm_addr(nvm_addr), .i_nvm_data(nvm_data),
        .i_save_addr(save_addr), .o_save_data(save_data),
        .i_status(status), .o_active_regs(active), .o_four_wire(four),
        .o_commit(commit), .o_soft_reset(srst), .o_pll_cal_start(cal),
        .o_loading(loading));
    scbu_spi_host i_host (.i_clk(clk), .i_sdio(sdio_ln), .i_sdo(sdo_ln),
        .o_sclk(sclk), .o_cs_n(cs_n), .o_d(host_d), .o_oe(host_oe));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one frame of up to two bytes through the host model
    task automatic xf(input logic rd, input logic [12:0] a, input int n,
            input logic [7:0] b0, b1, output logic [7:0] r0, r1);
        logic [7:0] w[8];
        logic [7:0] r[8];
        w = '{default: 8'h00};
        w[0] = b0;
        w[1] = b1;
        i_host.frame(rd, a, n, w, r);
        r0 = r[0];
        r1 = r[1];
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] r0, r1;
        xf(1'b0, a, 1, d, 8'h00, r0, r1);
    endtask
    task automatic rdc(input logic [12:0] a, input int n,
            input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] r0, r1;
        xf(1'b1, a, n, 8'h00, 8'h00, r0, r1);
        chk8(r0, e0);
        if (n > 1)
            chk8(r1, e1);
    endtask
    task automatic t_reset();
        rdc(13'h0000, 1, 8'h00, 8'h00);
        rdc(13'h0004, 1, 8'h00, 8'h00);
        rdc(13'h0005, 1, 8'h00, 8'h00);
        chk8({7'h0, four}, 8'h00);
    endtask
    // pending writes stay hidden until the commit
    task automatic t_commit();
        logic [7:0] r0, r1;
        int c;
        c = n_commit;
        wr(13'h0005, 8'hfe);
        chk8(8'(n_commit - c), 8'h00);
        xf(1'b0, 13'h0603, 2, 8'h5a, 8'hc3, r0, r1);
        chk8(active[3], 8'h00);
        rdc(13'h0603, 1, 8'h00, 8'h00);
        wr(13'h0004, 8'h01);
        rdc(13'h0603, 2, 8'h5a, 8'hc3);
        status = 8'h3c;
        wr(13'h0005, 8'h01);
        chk8(active[3], 8'h5a);
        chk8(active[2], 8'hc3);
        status = 8'h99;
        rdc(13'h0005, 1, 8'h00, 8'h00);
        rdc(13'h0d00, 1, 8'h3c, 8'h00);
        wr(13'h0004, 8'h00);
        rdc(13'h0602, 1, 8'hc3, 8'h00);
    endtask
    // four-wire, least significant first, rising addresses
    task automatic t_lsb();
        logic [7:0] r0, r1;
        wr(13'h0000, 8'hc0);
        i_host.lsb = 1'b1;
        i_host.four = 1'b1;
        chk8({7'h0, four}, 8'h01);
        save_addr = 13'h0000;
        repeat (2) @(posedge clk);
        #1;
        chk8(save_data, 8'h00);
        xf(1'b0, 13'h0604, 2, 8'h12, 8'h34, r0, r1);
        save_addr = 13'h0605;
        repeat (2) @(posedge clk);
        #1;
        chk8(save_data, 8'h34);
        wr(13'h0005, 8'h01);
        chk8(active[5], 8'h34);
        rdc(13'h0604, 2, 8'h12, 8'h34);
        rdc(13'h0000, 1, 8'hc0, 8'h00);
        wr(13'h0000, 8'h00);
        i_host.lsb = 1'b0;
        i_host.four = 1'b0;
        chk8({7'h0, four}, 8'h00);
    endtask
    // soft reset starts the selected download and clears the bank
    task automatic t_load(input logic pin, input logic [7:0] cfg, a0, a7);
        int c0, c1, c2;
        c0 = n_commit;
        c1 = n_cal;
        c2 = n_srst;
        {pin_pg, nvm_ld} = {pin, !pin};
        repeat (4) @(posedge clk);
        #1;
        wr(13'h0000, cfg);
        for (int i = 0; i < 300 && loading !== 1'b0; i++)
            @(posedge clk);
        #1;
        chk8(8'(n_srst - c2), 8'h01);
        chk8(8'(n_cal - c1), {7'h0, !pin});
        chk8(8'(n_commit - c0), 8'h01);
        chk8(active[0], a0);
        chk8(active[7], a7);
        chk8(active[4], 8'h00);
        chk8({7'h0, four}, 8'h00);
    endtask
    initial begin
        {rst_n, nvm_ld, pin_pg, pat_q} = 4'h0;
        save_addr = 13'h0603;
        status = 8'h00;
        nvm_data = 8'h00;
        foreach (nvm[i])
            nvm[i] = 8'hff;
        foreach (seq_nvm[i])
            nvm[i] = seq_nvm[i];
        foreach (seq_pin[i])
            nvm[10'h200 + i] = seq_pin[i];
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_commit();
        t_lsb();
        t_load(1'b0, 8'ha0, 8'h11, 8'h00);
        t_load(1'b1, 8'h20, 8'h00, 8'h55);
        complete_run();
    end
    // watchdog well past the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
